// File: rtl/sbgt_timer.sv
// Sixteen-bit gated timer with period match, APB registers and interrupt.
// Assumes an APB master on i_mclk and an asynchronous external count pin.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "sbgt_params.svh"

module sbgt_timer (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_sys_rst,
  // APB slave
  input  wire sbgt_pkg::sbgt_apb_req_t i_apb,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  // Power modes
  input  wire logic                  i_idle,
  input  wire logic                  i_sleep,
  // External count and gate pin
  input  wire logic                  i_external_count_pin,
  // Interrupt
  output logic                       o_irq,
  output logic [`SBGT_PRIO_W-1:0]    o_interrupt_priority_field
);
  import sbgt_pkg::*;

  sbgt_ctrl_t              ctrl_reg;
  logic [15:0]             period_reg;
  logic [15:0]             count_reg;
  logic [`SBGT_IRQ_W-1:0]  status_reg;
  logic [`SBGT_IRQ_W-1:0]  enable_reg;
  logic [`SBGT_PRIO_W-1:0] prio_reg;
  logic [31:0]             rdata_reg;
  logic                    slverr_reg;
  logic [2:0]              pin_s_reg;
  logic                    pin_lvl_reg;

  logic                    acc;
  logic                    setup;
  logic                    wr_ctrl;
  logic                    wr_period;
  logic                    wr_count;
  logic                    wr_clear;
  logic                    wr_enable;
  logic                    wr_prio;
  logic                    pin_agree;
  logic                    pin_rise;
  logic                    pin_fall;
  logic                    gate_mode;
  logic                    ext_async;
  logic                    run_en;
  logic                    src_tick;
  logic                    cnt_tick;
  logic                    at_period;
  logic                    match_evt;
  logic                    gate_evt;
  logic [`SBGT_IRQ_W-1:0]  evt;
  logic [`SBGT_IRQ_W-1:0]  clr_mask;
  logic [15:0]             ctrl_rd;
  logic [31:0]             rdata_next;
  logic                    slverr_next;
  logic [7:0]              gap_reg;
  logic [7:0]              div_last;

  // APB decode
  assign setup     = i_apb.psel && !i_apb.penable;
  assign acc       = i_apb.psel && i_apb.penable;
  assign wr_ctrl   = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_CTRL);
  assign wr_period = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_PERIOD);
  assign wr_count  = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_COUNT);
  assign wr_clear  = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_CLEAR);
  assign wr_enable = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_ENABLE);
  assign wr_prio   = acc && i_apb.pwrite && (i_apb.paddr == `SBGT_OFS_PRIO);
  assign o_pready  = 1'b1;
  assign o_prdata  = rdata_reg;
  assign o_pslverr = slverr_reg && acc;

  // Control register image, unimplemented bits zero
  always_comb begin
    ctrl_rd                = 16'h0000;
    ctrl_rd[`SBGT_B_RUN]   = ctrl_reg.run;
    ctrl_rd[`SBGT_B_IDLE]  = ctrl_reg.idle_halt;
    ctrl_rd[`SBGT_B_GATE]  = ctrl_reg.gate_en;
    ctrl_rd[`SBGT_B_DIV_HI:`SBGT_B_DIV_LO] = ctrl_reg.div_sel;
    ctrl_rd[`SBGT_B_SYNC]  = ctrl_reg.sync_sel;
    ctrl_rd[`SBGT_B_CS]    = ctrl_reg.cs;
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    rdata_next  = 32'h0000_0000;
    slverr_next = 1'b0;
    case (i_apb.paddr)
      `SBGT_OFS_CTRL:   rdata_next[15:0] = ctrl_rd;
      `SBGT_OFS_PERIOD: rdata_next[15:0] = period_reg;
      `SBGT_OFS_COUNT:  rdata_next[15:0] = count_reg;
      `SBGT_OFS_STATUS: rdata_next[`SBGT_IRQ_W-1:0] = status_reg;
      `SBGT_OFS_CLEAR:  rdata_next = 32'h0000_0000;
      `SBGT_OFS_ENABLE: rdata_next[`SBGT_IRQ_W-1:0] = enable_reg;
      `SBGT_OFS_PRIO:   rdata_next[`SBGT_PRIO_W-1:0] = prio_reg;
      default:          slverr_next = 1'b1;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_reg  <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg  <= i_apb.pwrite ? 32'h0000_0000 : rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // Control register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_reg <= sbgt_ctrl_t'(`SBGT_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_reg.run       <= i_apb.pwdata[`SBGT_B_RUN];
      ctrl_reg.idle_halt <= i_apb.pwdata[`SBGT_B_IDLE];
      ctrl_reg.gate_en   <= i_apb.pwdata[`SBGT_B_GATE];
      ctrl_reg.div_sel   <= sbgt_div_t'(i_apb.pwdata[`SBGT_B_DIV_HI:`SBGT_B_DIV_LO]);
      ctrl_reg.sync_sel  <= i_apb.pwdata[`SBGT_B_SYNC];
      ctrl_reg.cs        <= i_apb.pwdata[`SBGT_B_CS];
    end
  end

  // Period, enable and priority registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      period_reg <= `SBGT_PERIOD_RST;
      enable_reg <= `SBGT_IRQ_RST;
      prio_reg   <= `SBGT_PRIO_RST;
    end else begin
      if (wr_period) begin
        period_reg <= i_apb.pwdata[15:0];
      end
      if (wr_enable) begin
        enable_reg <= i_apb.pwdata[`SBGT_IRQ_W-1:0];
      end
      if (wr_prio) begin
        prio_reg <= i_apb.pwdata[`SBGT_PRIO_W-1:0];
      end
    end
  end

  // Pin synchronizer: a change counts once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_s_reg   <= 3'h0;
      pin_lvl_reg <= 1'b0;
    end else begin
      pin_s_reg <= {pin_s_reg[1:0], i_external_count_pin};
      if (pin_agree) begin
        pin_lvl_reg <= pin_s_reg[2];
      end
    end
  end

  assign pin_agree = (pin_s_reg[1] == pin_s_reg[2]);
  assign pin_rise  = pin_agree && pin_s_reg[2] && !pin_lvl_reg;
  assign pin_fall  = pin_agree && !pin_s_reg[2] && pin_lvl_reg;

  // Source selection and run qualification
  assign gate_mode = !ctrl_reg.cs && ctrl_reg.gate_en;
  assign ext_async = ctrl_reg.cs && !ctrl_reg.sync_sel;
  assign run_en    = ctrl_reg.run
                     && !(ctrl_reg.idle_halt && i_idle)
                     && !(i_sleep && !ext_async);

  always_comb begin
    if (ctrl_reg.cs) begin
      src_tick = pin_rise;
    end else if (gate_mode) begin
      src_tick = pin_lvl_reg;
    end else begin
      src_tick = 1'b1;
    end
  end

  sbgt_prescaler #(
    .W (8)
  ) u_presc (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (!ctrl_reg.run || wr_ctrl),
    .i_div_sel (ctrl_reg.div_sel),
    .i_tick    (src_tick && run_en),
    .o_tick    (cnt_tick)
  );

  // Counter
  assign at_period = (count_reg == period_reg);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      count_reg <= `SBGT_COUNT_RST;
    end else if (wr_count) begin
      count_reg <= i_apb.pwdata[15:0];
    end else if (cnt_tick) begin
      count_reg <= at_period ? 16'h0000 : count_reg + 16'h0001;
    end
  end

  // Interrupt events, status, and set-over-clear
  assign match_evt = cnt_tick && at_period && !gate_mode;
  assign gate_evt  = gate_mode && run_en && pin_fall;

  always_comb begin
    evt                  = '0;
    evt[`SBGT_IRQ_MATCH] = match_evt;
    evt[`SBGT_IRQ_GATE]  = gate_evt;
    clr_mask             = wr_clear ? i_apb.pwdata[`SBGT_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      status_reg <= `SBGT_IRQ_RST;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | evt;
    end
  end

  assign o_irq                      = |(status_reg & enable_reg);
  assign o_interrupt_priority_field = prio_reg;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_ctrl_unimpl_zero: assert property (
    (setup && !i_apb.pwrite && i_apb.paddr == `SBGT_OFS_CTRL)
    |=> ((o_prdata & ~{16'h0000, `SBGT_CTRL_MASK}) == 32'h0000_0000))
    else $error("Unimplemented control bits read nonzero");

  a_reset_ctrl_zero: assert property (
    $fell(i_sys_rst) |-> (ctrl_rd == `SBGT_CTRL_RST))
    else $error("Control register not zero after reset");

  a_stop_hold: assert property (
    (!run_en && !wr_count)
    |=> $stable(count_reg))
    else $error("Count moved while stopped");

  a_idle_hold: assert property (
    (ctrl_reg.idle_halt && i_idle && !wr_count)
    |=> $stable(count_reg))
    else $error("Count moved in Idle with halt selected");

  a_sleep_hold: assert property (
    (i_sleep && !ext_async && !wr_count)
    |=> $stable(count_reg))
    else $error("Count moved in Sleep without asynchronous source");

  a_gate_low_hold: assert property (
    (gate_mode && !pin_lvl_reg && !wr_count)
    |=> $stable(count_reg))
    else $error("Count moved while gate low");

  a_ext_rise_only: assert property (
    (ctrl_reg.cs && !pin_rise)
    |-> !cnt_tick)
    else $error("External count without a pin rising edge");

  a_count_wrap: assert property (
    (cnt_tick && at_period && !wr_count)
    |=> (count_reg == 16'h0000))
    else $error("Count did not wrap to zero at period");

  a_count_step: assert property (
    (cnt_tick && !at_period && !wr_count)
    |=> (count_reg == $past(count_reg) + 16'h0001))
    else $error("Count did not advance by one");

  a_match_flag: assert property (
    match_evt
    |=> status_reg[`SBGT_IRQ_MATCH])
    else $error("Period match flag not set");

  a_gate_fall_flag: assert property (
    gate_evt
    |=> status_reg[`SBGT_IRQ_GATE])
    else $error("Gate falling edge flag not set");

  // Independent ratio model: source ticks since the last prescaled tick
  always_comb begin
    case (ctrl_reg.div_sel)
      SBGT_DIV1:   div_last = `SBGT_DIV1_LAST;
      SBGT_DIV8:   div_last = `SBGT_DIV8_LAST;
      SBGT_DIV64:  div_last = `SBGT_DIV64_LAST;
      SBGT_DIV256: div_last = `SBGT_DIV256_LAST;
      default:     div_last = `SBGT_DIV1_LAST;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !ctrl_reg.run || wr_ctrl) begin
      gap_reg <= 8'h00;
    end else if (src_tick && run_en) begin
      gap_reg <= (gap_reg == div_last) ? 8'h00 : gap_reg + 8'h01;
    end
  end

  a_div_ratio: assert property (
    (src_tick && run_en && !wr_ctrl)
    |-> (cnt_tick == (gap_reg == div_last)))
    else $error("Prescaled tick at the wrong ratio");

  // Main scenarios
  c_period_match: cover property (match_evt);

  c_gate_fall: cover property (gate_evt);

  c_ext_count: cover property (ctrl_reg.cs && cnt_tick);

  c_idle_halted: cover property (ctrl_reg.run && ctrl_reg.idle_halt && i_idle);

endmodule // sbgt_timer

// File: rtl/sbgt_params.svh
// Constants for the sixteen-bit gated timer: offsets, field positions,
// reset values and prescaler terminal counts.
// Assumes it is included by bare name from the rtl/ folder.
`ifndef SBGT_PARAMS_SVH
`define SBGT_PARAMS_SVH

// Register byte offsets on APB
`define SBGT_AW          8
`define SBGT_OFS_CTRL    8'h00
`define SBGT_OFS_PERIOD  8'h04
`define SBGT_OFS_COUNT   8'h08
`define SBGT_OFS_STATUS  8'h0c
`define SBGT_OFS_CLEAR   8'h10
`define SBGT_OFS_ENABLE  8'h14
`define SBGT_OFS_PRIO    8'h18

// Control field positions
`define SBGT_B_RUN       15
`define SBGT_B_IDLE      13
`define SBGT_B_GATE      6
`define SBGT_B_DIV_HI    5
`define SBGT_B_DIV_LO    4
`define SBGT_B_SYNC      2
`define SBGT_B_CS        1
`define SBGT_CTRL_MASK   16'ha076

// Interrupt status layout
`define SBGT_IRQ_W       2
`define SBGT_IRQ_MATCH   0
`define SBGT_IRQ_GATE    1
`define SBGT_PRIO_W      3

// Reset values
`define SBGT_CTRL_RST    16'h0000
`define SBGT_PERIOD_RST  16'hffff
`define SBGT_COUNT_RST   16'h0000
`define SBGT_PRIO_RST    3'h0
`define SBGT_IRQ_RST     2'h0

// Prescaler terminal counts
`define SBGT_DIV1_LAST   8'h00
`define SBGT_DIV8_LAST   8'h07
`define SBGT_DIV64_LAST  8'h3f
`define SBGT_DIV256_LAST 8'hff

`endif

// File: rtl/sbgt_pkg.sv
// Types shared by the sixteen-bit gated timer files.
// Assumes nothing beyond a SystemVerilog compiler.
package sbgt_pkg;

  typedef enum logic [1:0] {
    SBGT_DIV1   = 2'b00,
    SBGT_DIV8   = 2'b01,
    SBGT_DIV64  = 2'b10,
    SBGT_DIV256 = 2'b11
  } sbgt_div_t;

  typedef struct packed {
    logic      run;
    logic      idle_halt;
    logic      gate_en;
    sbgt_div_t div_sel;
    logic      sync_sel;
    logic      cs;
  } sbgt_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sbgt_apb_req_t;

endpackage

// File: rtl/sbgt_prescaler.sv
// Input prescaler: passes one of every 1, 8, 64 or 256 source ticks.
// Assumes source ticks are one-cycle pulses on i_mclk.
`timescale 1ns/1ns
`include "sbgt_params.svh"

module sbgt_prescaler #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  // Control
  input  wire logic               i_clear,
  input  wire sbgt_pkg::sbgt_div_t i_div_sel,
  // Ticks
  input  wire logic               i_tick,
  output logic                    o_tick
);
  import sbgt_pkg::*;

  logic [W-1:0] cnt_reg;
  logic [W-1:0] last;

  always_comb begin
    case (i_div_sel)
      SBGT_DIV1:   last = W'(`SBGT_DIV1_LAST);
      SBGT_DIV8:   last = W'(`SBGT_DIV8_LAST);
      SBGT_DIV64:  last = W'(`SBGT_DIV64_LAST);
      SBGT_DIV256: last = W'(`SBGT_DIV256_LAST);
      default:     last = W'(`SBGT_DIV1_LAST);
    endcase
  end

  assign o_tick = i_tick && (cnt_reg == last);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_clear) begin
      cnt_reg <= '0;
    end else if (i_tick) begin
      cnt_reg <= (cnt_reg == last) ? '0 : cnt_reg + 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_div1_pass: assert property (
    (i_div_sel == SBGT_DIV1) |-> (o_tick == i_tick))
    else $error("Divide by one does not pass every tick");

  a_div8_gap: assert property (
    (o_tick && i_div_sel == SBGT_DIV8 && !i_clear) ##1 (i_div_sel == SBGT_DIV8 && !i_clear)[*7]
    |-> !$past(o_tick))
    else $error("Divide by eight ticks too often");

endmodule // sbgt_prescaler

// File: test/sbgt_pin_model.sv
// External count and gate pin model for the gated timer bench.
// Assumes the bench picks a static level or a toggle half period.
`timescale 1ns/1ns
module sbgt_pin_model (
  // Clock
  input  wire logic       i_mclk,
  // Bench control
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  input  wire logic       i_level,
  // Pin
  output logic            o_pin
);
  logic [7:0] cnt;
  initial begin
    o_pin = 1'b0;
    cnt = 8'h00;
  end
  // Square wave while running, otherwise a static gate level
  always @(posedge i_mclk) begin
    if (!i_run) begin
      o_pin <= i_level;
      cnt <= 8'h00;
    end else if (cnt == i_half - 8'h01) begin
      o_pin <= !o_pin;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // sbgt_pin_model

// File: test/sbgt_timer_tb.sv
// Self-checking bench for the sixteen-bit gated timer.
// Assumes zero-wait APB and the pin model on the external pin.
`timescale 1ns/1ns
`include "sbgt_params.svh"
module sbgt_timer_tb;
  import sbgt_pkg::*;
  logic          i_mclk, i_sys_rst, i_idle, i_sleep, pin, p_run, p_lvl;
  logic          o_pready, o_pslverr, o_irq;
  logic [31:0]   o_prdata;
  logic [2:0]    o_prio;
  sbgt_apb_req_t req;
  logic [32:0]   exp_q[$];
  int            cyc = 0;
  int            n_fail, num_checks;
  int            div_tab[4] = '{1, 8, 64, 256};
  logic [19:0]   pm_tab[7] = '{20'ha0008, 20'h80009, 20'ha0001, 20'h80004,
                               20'h80027, 20'h80066, 20'h00022};
  logic [15:0]   ext_tab[3] = '{16'h8002, 16'h8006, 16'h8042};

  sbgt_timer i_sbgt_timer (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_apb(req),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_idle(i_idle),
    .i_sleep(i_sleep), .i_external_count_pin(pin), .o_irq(o_irq),
    .o_interrupt_priority_field(o_prio));
  sbgt_pin_model i_sbgt_pin_model (.i_mclk(i_mclk), .i_run(p_run), .i_half(8'd5),
    .i_level(p_lvl), .o_pin(pin));

  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_mclk);
    req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k == 16) begin
      chk(33'h0, 33'h1);
      finish_test;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input int lim, output logic hit);
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(posedge i_mclk);
      #1;
      hit = (o_irq === 1'b1);
    end
  endtask
  task automatic period_of(output int n);
    logic h;
    int t0;
    wait_irq(5000, h);
    t0 = cyc;
    wr(`SBGT_OFS_CLEAR, 32'h3);
    wait_irq(5000, h);
    n = h ? cyc - t0 : 0;
  endtask
  task automatic restart(input logic [31:0] c, input logic [31:0] p);
    wr(`SBGT_OFS_CTRL, 32'h0);
    wr(`SBGT_OFS_PERIOD, p);
    wr(`SBGT_OFS_CLEAR, 32'h3);
    wr(`SBGT_OFS_COUNT, 32'h0);
    wr(`SBGT_OFS_CTRL, c);
  endtask

  // Read results are matched against the oldest noted expectation
  always @(posedge i_mclk) begin
    if (req.psel && req.penable && o_pready === 1'b1 && !req.pwrite) begin
      if (exp_q.size() == 0) chk({o_pslverr, o_prdata}, 33'h1ffffffff);
      else chk({o_pslverr, o_prdata}, exp_q.pop_front());
    end
  end
  always @(posedge i_mclk) cyc <= cyc + 1;
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    logic [31:0] r;
    int n;
    logic h;
    req = '0;
    {i_idle, i_sleep, p_run, p_lvl} = 4'h0;
    n_fail = 0;
    num_checks = 0;
    i_sys_rst = 1'b1;
    r = $urandom(30888);
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(`SBGT_OFS_CTRL, 33'h0);
    rd(`SBGT_OFS_PERIOD, 33'hffff);
    rd(`SBGT_OFS_COUNT, 33'h0);
    rd(`SBGT_OFS_STATUS, 33'h0);
    rd(8'h1c, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      wr(`SBGT_OFS_CTRL, r);
      rd(`SBGT_OFS_CTRL, {17'h0, r[15:0] & 16'ha076});
      wr(`SBGT_OFS_PRIO, r);
      rd(`SBGT_OFS_PRIO, {30'h0, r[2:0]});
      chk({30'h0, o_prio}, {30'h0, r[2:0]});
    end
    wr(`SBGT_OFS_CTRL, 32'h0);
    wr(`SBGT_OFS_COUNT, 32'h7);
    repeat (20) @(posedge i_mclk);
    rd(`SBGT_OFS_COUNT, 33'h7);
    wr(`SBGT_OFS_ENABLE, 32'h1);
    for (int d = 0; d < 4; d++) begin
      restart(32'h8000 | (d << 4), 32'hf);
      period_of(n);
      chk(33'(n), 33'(16 * div_tab[d]));
    end
    wr(`SBGT_OFS_ENABLE, 32'h0);
    #1;
    chk(33'(o_irq), 33'h0);
    rd(`SBGT_OFS_STATUS, 33'h1);
    wr(`SBGT_OFS_ENABLE, 32'h1);
    #1;
    chk(33'(o_irq), 33'h1);
    wr(`SBGT_OFS_CTRL, 32'h0);
    wr(`SBGT_OFS_CLEAR, 32'h3);
    #1;
    chk(33'(o_irq), 33'h0);
    for (int i = 0; i < 7; i++) begin
      {i_idle, i_sleep, p_run} <= pm_tab[i][3:1];
      restart({16'h0, pm_tab[i][19:4]}, 32'h3);
      wait_irq(100, h);
      chk(33'(h), 33'(pm_tab[i][0]));
    end
    {i_idle, i_sleep} <= 2'b00;
    p_run <= 1'b1;
    wr(`SBGT_OFS_ENABLE, 32'h3);
    for (int i = 0; i < 3; i++) begin
      restart({16'h0, ext_tab[i]}, 32'h4);
      period_of(n);
      chk(33'(n), 33'd50);
      rd(`SBGT_OFS_STATUS, 33'h1);
    end
    p_run <= 1'b0;
    wr(`SBGT_OFS_ENABLE, 32'h2);
    restart(32'h8040, 32'hffff);
    repeat (10) @(posedge i_mclk);
    rd(`SBGT_OFS_COUNT, 33'h0);
    p_lvl <= 1'b1;
    repeat (30) @(posedge i_mclk);
    p_lvl <= 1'b0;
    wait_irq(20, h);
    chk(33'(h), 33'h1);
    rd(`SBGT_OFS_STATUS, 33'h2);
    rd(`SBGT_OFS_COUNT, 33'd30);
    finish_test;
  end
endmodule // sbgt_timer_tb
